/* File: core/wsp_top.sv */
// The implementer's own choices: the register offsets and the plain strobed port.
`timescale 1ns/100ps
`default_nettype none
module wsp_top #(
  parameter logic [11:0] SETTLE_LOAD = wsp_pkg::WDT_SETTLE_LOAD
) (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic reset_i,
  // Register port
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o,
  // Core events
  input wire logic stop_instr_i,
  input wire logic wait_instr_i,
  input wire logic irq_accept_i,
  input wire logic byte_mode_i,
  // Bus unit side of the external bus
  input wire logic [23:0] bus_addr_i,
  input wire logic [15:0] bus_dout_i,
  input wire logic bus_doe_i,
  input wire logic [3:0] bus_ctl_i,
  // Port registers: address P10,P11,P0; data P1,P2; ctl P31..P33,P90
  input wire logic [23:0] port_addr_out_i,
  input wire logic [23:0] port_addr_dir_i,
  input wire logic [15:0] port_data_out_i,
  input wire logic [15:0] port_data_dir_i,
  input wire logic [3:0] port_ctl_out_i,
  input wire logic [3:0] port_ctl_dir_i,
  // Pins: ctl bit0 read, 1 low_byte_write_strobe, 2 high_byte_write_strobe, 3 area0_chip_select
  output logic [23:0] addr_pin_o,
  output logic [23:0] addr_pin_oe_o,
  output logic [15:0] data_pin_o,
  output logic [15:0] data_pin_oe_o,
  output logic [3:0] ctl_pin_o,
  output logic [3:0] ctl_pin_oe_o,
  // Clocks
  output logic bus_unit_clock_o,
  output logic core_clock_o,
  output logic watchdog_div32_clock_o,
  output logic watchdog_div512_clock_o,
  output logic [12:0] periph_div_clk_o,
  // Oscillator
  output logic osc_run_o,
  output logic osc_drive_en_o,
  output logic osc_output_pin_o,
  // Peripheral run levels
  output logic refresh_run_o,
  output logic adc_run_o,
  output logic dma_run_o,
  output logic wdt_run_o,
  output logic event_only_o,
  output logic vref_connect_o
);
  typedef struct packed {
    wsp_pkg::wsp_state_type st;
    logic deep;
    logic [12:0] div;
    logic [11:0] wdt;
    logic stp_dis;
    logic ext_sel;
    logic stp_flag;
    logic wit_flag;
    logic standby_sel;
    logic deep_sel;
    logic vref_off;
    logic [6:0] vref_cnt;
    logic [7:0] rdata;
    logic osc_run;
    logic osc_drive;
    logic osc_out;
    logic refresh;
    logic adc_run;
    logic dma_run;
    logic wdt_run;
    logic ev_only;
    logic vref_conn;
    logic [23:0] addr_pin;
    logic [23:0] addr_oe;
    logic [15:0] data_pin;
    logic [15:0] data_oe;
    logic [3:0] ctl_pin;
    logic [3:0] ctl_oe;
  } wsp_top_state_type;

  wsp_top_state_type s_q;
  wsp_top_state_type s_d;
  logic osc_on;
  logic wdg_tick;
  logic hand_d;
  logic hi_hand;
  logic deep_wait_d;
  logic [1:0] core_clks;
  logic [1:0] wdg_clks;
  logic [1:0] wdg_run;

  if (!SETTLE_LOAD[wsp_pkg::WDT_W-1]) begin : g_chk
    $error("SETTLE_LOAD must have its top bit set");
  end

  // Next state of the whole block
  always_comb begin
    s_d = s_q;
    // Oscillator stops in stop state once the divider chain is at zero
    osc_on = !(s_q.st == wsp_pkg::ST_STOP && s_q.div == '0);
    s_d.div = osc_on ? s_q.div + 13'h0001 : s_q.div;
    wdg_tick = s_d.div[wsp_pkg::WDG32_BIT] && !s_q.div[wsp_pkg::WDG32_BIT];
    // Register writes first, so hardware flag sets below win
    if (reg_wr_i) begin
      case (reg_addr_i)
        wsp_pkg::REG_FUNC_SEL0: begin
          s_d.stp_dis = reg_wdata_i[wsp_pkg::FS0_STOP_DIS];
          s_d.ext_sel = reg_wdata_i[wsp_pkg::FS0_EXT_CLK];
        end
        wsp_pkg::REG_FUNC_SEL1: begin
          s_d.stp_flag = reg_wdata_i[wsp_pkg::FS1_STOP_FLAG];
          s_d.wit_flag = reg_wdata_i[wsp_pkg::FS1_WAIT_FLAG];
          s_d.standby_sel = reg_wdata_i[wsp_pkg::FS1_STANDBY_SEL];
          s_d.deep_sel = reg_wdata_i[wsp_pkg::FS1_DEEP_WAIT];
        end
        wsp_pkg::REG_ADC_CTRL1: begin
          s_d.vref_off = reg_wdata_i[wsp_pkg::ADC1_VREF_OFF];
        end
        default: begin
        end
      endcase
    end
    // Reconnect settling counter
    if (s_q.vref_off && !s_d.vref_off) begin
      s_d.vref_cnt = wsp_pkg::VREF_SETTLE_CYC;
    end else if (s_q.vref_cnt != '0) begin
      s_d.vref_cnt = s_q.vref_cnt - 7'h01;
    end
    // Power state sequencing
    case (s_q.st)
      wsp_pkg::ST_RUN: begin
        if (stop_instr_i && !s_q.stp_dis) begin
          s_d.st = wsp_pkg::ST_STOP;
          s_d.stp_flag = 1'b1;
          s_d.wdt = SETTLE_LOAD;
        end else if (wait_instr_i) begin
          s_d.st = wsp_pkg::ST_WAIT;
          s_d.wit_flag = 1'b1;
          s_d.deep = s_d.deep_sel;
        end
      end
      wsp_pkg::ST_WAIT: begin
        if (irq_accept_i) begin
          s_d.st = wsp_pkg::ST_RUN;
        end
      end
      wsp_pkg::ST_STOP: begin
        if (irq_accept_i) begin
          s_d.st = s_q.ext_sel ? wsp_pkg::ST_RUN : wsp_pkg::ST_SETTLE;
        end
      end
      wsp_pkg::ST_SETTLE: begin
        if (!s_q.wdt[wsp_pkg::WDT_W-1]) begin
          s_d.st = wsp_pkg::ST_RUN;
        end else if (wdg_tick) begin
          s_d.wdt = s_q.wdt - 12'h001;
        end
      end
      default: begin
        s_d.st = wsp_pkg::ST_RUN;
      end
    endcase
    // Run levels follow the next state, so they line up with the state register
    deep_wait_d = (s_d.st == wsp_pkg::ST_WAIT) && s_d.deep;
    s_d.osc_run = !(s_d.st == wsp_pkg::ST_STOP && s_d.div == '0);
    s_d.osc_drive = s_d.osc_run && !s_d.ext_sel;
    s_d.osc_out = s_d.ext_sel;
    s_d.refresh = (s_d.st != wsp_pkg::ST_STOP);
    s_d.adc_run = (s_d.st != wsp_pkg::ST_STOP) && !deep_wait_d;
    s_d.dma_run = (s_d.st == wsp_pkg::ST_RUN);
    s_d.wdt_run = (s_d.st == wsp_pkg::ST_RUN);
    s_d.ev_only = (s_d.st == wsp_pkg::ST_STOP) || deep_wait_d;
    s_d.vref_conn = !s_d.vref_off;
    // Pin handover while stopped, waiting or settling
    hand_d = s_d.standby_sel && (s_d.st != wsp_pkg::ST_RUN);
    hi_hand = hand_d || byte_mode_i;
    s_d.addr_pin = hand_d ? port_addr_out_i : bus_addr_i;
    s_d.addr_oe = hand_d ? port_addr_dir_i : 24'hFFFFFF;
    s_d.data_pin[7:0] = hand_d ? port_data_out_i[7:0] : bus_dout_i[7:0];
    s_d.data_oe[7:0] = hand_d ? port_data_dir_i[7:0] : {8{bus_doe_i}};
    s_d.data_pin[15:8] = hi_hand ? port_data_out_i[15:8] : bus_dout_i[15:8];
    s_d.data_oe[15:8] = hi_hand ? port_data_dir_i[15:8] : {8{bus_doe_i}};
    for (int i = 0; i < 4; i++) begin
      if ((i == 2) ? hi_hand : hand_d) begin
        s_d.ctl_pin[i] = port_ctl_out_i[i];
        s_d.ctl_oe[i] = port_ctl_dir_i[i];
      end else begin
        s_d.ctl_pin[i] = bus_ctl_i[i];
        s_d.ctl_oe[i] = 1'b1;
      end
    end
    // Read data stand for one cycle only
    s_d.rdata = 8'h00;
    if (reg_rd_i) begin
      case (reg_addr_i)
        wsp_pkg::REG_FUNC_SEL0: s_d.rdata = {6'h00, s_q.ext_sel, s_q.stp_dis};
        wsp_pkg::REG_FUNC_SEL1: s_d.rdata = {4'h0, s_q.deep_sel, s_q.standby_sel, s_q.wit_flag, s_q.stp_flag};
        wsp_pkg::REG_ADC_CTRL1: s_d.rdata = {1'b0, s_q.vref_off, 6'h00};
        wsp_pkg::REG_STANDBY_STAT: s_d.rdata = {4'h0, !s_q.vref_off && s_q.vref_cnt == '0,
          s_q.st == wsp_pkg::ST_SETTLE, s_q.st == wsp_pkg::ST_STOP, s_q.st == wsp_pkg::ST_WAIT};
        default: s_d.rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      s_q <= '0;
      s_q.st <= wsp_pkg::ST_RUN;
      s_q.stp_dis <= wsp_pkg::FUNC_SEL0_RST[wsp_pkg::FS0_STOP_DIS];
      s_q.ext_sel <= wsp_pkg::FUNC_SEL0_RST[wsp_pkg::FS0_EXT_CLK];
      s_q.standby_sel <= wsp_pkg::FUNC_SEL1_RST[wsp_pkg::FS1_STANDBY_SEL];
      s_q.deep_sel <= wsp_pkg::FUNC_SEL1_RST[wsp_pkg::FS1_DEEP_WAIT];
      s_q.vref_off <= wsp_pkg::ADC1_VREF_OFF_RST;
      s_q.osc_run <= 1'b1;
      s_q.osc_drive <= 1'b1;
      s_q.refresh <= 1'b1;
      s_q.adc_run <= 1'b1;
      s_q.dma_run <= 1'b1;
      s_q.wdt_run <= 1'b1;
      s_q.vref_conn <= 1'b1;
      s_q.addr_oe <= 24'hFFFFFF;
      s_q.ctl_oe <= 4'hF;
      s_q.ctl_pin <= 4'hF;
    end else begin
      s_q <= s_d;
    end
  end

  // Gated clocks: bus unit and core run only in the run state
  wsp_clk_gate #(.W(2)) u_core_gate (
    .core_clk_i(core_clk_i),
    .reset_i(reset_i),
    .src_i({2{s_d.div[0]}}),
    .run_i({2{s_d.st == wsp_pkg::ST_RUN}}),
    .clk_o(core_clks)
  );

  // Watchdog clocks: divide-by-32 also runs while settling
  assign wdg_run[0] = (s_d.st == wsp_pkg::ST_RUN) || (s_d.st == wsp_pkg::ST_SETTLE);
  assign wdg_run[1] = (s_d.st == wsp_pkg::ST_RUN);
  wsp_clk_gate #(.W(2)) u_wdg_gate (
    .core_clk_i(core_clk_i),
    .reset_i(reset_i),
    .src_i({s_d.div[wsp_pkg::WDG512_BIT], s_d.div[wsp_pkg::WDG32_BIT]}),
    .run_i(wdg_run),
    .clk_o(wdg_clks)
  );

  // Divided peripheral clocks stop in stop and in deep wait
  wsp_clk_gate #(.W(wsp_pkg::DIV_W)) u_periph_gate (
    .core_clk_i(core_clk_i),
    .reset_i(reset_i),
    .src_i(s_d.div),
    .run_i({wsp_pkg::DIV_W{(s_d.st != wsp_pkg::ST_STOP) && !deep_wait_d}}),
    .clk_o(periph_div_clk_o)
  );

  // Outputs
  assign bus_unit_clock_o = core_clks[0];
  assign core_clock_o = core_clks[1];
  assign watchdog_div32_clock_o = wdg_clks[0];
  assign watchdog_div512_clock_o = wdg_clks[1];
  assign reg_rdata_o = s_q.rdata;
  assign osc_run_o = s_q.osc_run;
  assign osc_drive_en_o = s_q.osc_drive;
  assign osc_output_pin_o = s_q.osc_out;
  assign refresh_run_o = s_q.refresh;
  assign adc_run_o = s_q.adc_run;
  assign dma_run_o = s_q.dma_run;
  assign wdt_run_o = s_q.wdt_run;
  assign event_only_o = s_q.ev_only;
  assign vref_connect_o = s_q.vref_conn;
  assign addr_pin_o = s_q.addr_pin;
  assign addr_pin_oe_o = s_q.addr_oe;
  assign data_pin_o = s_q.data_pin;
  assign data_pin_oe_o = s_q.data_oe;
  assign ctl_pin_o = s_q.ctl_pin;
  assign ctl_pin_oe_o = s_q.ctl_oe;

  // Assertions
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (reset_i);

  a_wait_core_low: assert property ((s_q.st == wsp_pkg::ST_WAIT)[*3] |-> !bus_unit_clock_o && !core_clock_o)
    else $error("core clocks running in wait");
  a_deep_wait_off: assert property ((s_q.st == wsp_pkg::ST_WAIT && s_q.deep)[*3] |-> !periph_div_clk_o[0] && osc_run_o)
    else $error("deep wait left fast divided clock or oscillator wrong");
  a_deep_periph_stop: assert property (s_q.st == wsp_pkg::ST_WAIT && s_q.deep |-> !adc_run_o && !dma_run_o && event_only_o)
    else $error("converter or DMA running in deep wait");
  a_refresh_wait: assert property (s_q.st == wsp_pkg::ST_WAIT |-> refresh_run_o)
    else $error("refresh stopped in wait");
  // The slow watchdog clock may finish its high phase after entry, but it must never rise in wait
  a_wdt_halt_wait: assert property (s_q.st == wsp_pkg::ST_WAIT |-> !wdt_run_o && !$rose(watchdog_div512_clock_o))
    else $error("watchdog running in wait");
  a_irq_ends_wait: assert property (s_q.st == wsp_pkg::ST_WAIT && irq_accept_i |=> s_q.st == wsp_pkg::ST_RUN ##2 dma_run_o)
    else $error("interrupt did not end wait");
  a_handover_pins: assert property (hand_d |=> addr_pin_o == $past(port_addr_out_i) && ctl_pin_oe_o[3] == $past(port_ctl_dir_i[3]))
    else $error("pins not handed to ports");
  a_bus_restored: assert property (!hand_d && !byte_mode_i |=> data_pin_o == $past(bus_dout_i) && addr_pin_oe_o == 24'hFFFFFF)
    else $error("bus function not restored");
  a_byte_mode_port: assert property (byte_mode_i |=> data_pin_oe_o[15:8] == $past(port_data_dir_i[15:8]))
    else $error("upper data not a port in byte mode");
  a_ext_clk_osc_output_pin: assert property (s_q.ext_sel |-> osc_output_pin_o && !osc_drive_en_o)
    else $error("crystal driver active with external clock");
  a_ext_stop_exit: assert property (s_q.st == wsp_pkg::ST_STOP && s_q.ext_sel && irq_accept_i |=> s_q.st == wsp_pkg::ST_RUN)
    else $error("external clock stop exit waited");
  a_settle_core_low: assert property (s_q.st == wsp_pkg::ST_SETTLE && s_q.wdt[11] |=> !core_clock_o)
    else $error("core clock before watchdog settled");
  a_vref_off: assert property (s_q.vref_off |-> !vref_connect_o)
    else $error("ladder connected while disconnect set");
  a_flag_set: assert property (s_q.st == wsp_pkg::ST_RUN && stop_instr_i && !s_q.stp_dis |=> s_q.stp_flag[*2])
    else $error("stop flag not set");

  c_deep_wait: cover property (s_q.st == wsp_pkg::ST_WAIT && s_q.deep ##1 irq_accept_i);
  c_settle_done: cover property (s_q.st == wsp_pkg::ST_SETTLE ##1 s_q.st == wsp_pkg::ST_RUN);
  c_handover: cover property (hand_d && byte_mode_i);
endmodule
`default_nettype wire

/* File: pkg/wsp_pkg.sv */
package wsp_pkg;
  // Register offsets
  localparam logic [7:0] REG_ADC_CTRL1 = 8'h1F;
  localparam logic [7:0] REG_FUNC_SEL0 = 8'h62;
  localparam logic [7:0] REG_FUNC_SEL1 = 8'h63;
  localparam logic [7:0] REG_STANDBY_STAT = 8'h68;
  // Field positions
  localparam int FS0_STOP_DIS = 0;
  localparam int FS0_EXT_CLK = 1;
  localparam int FS1_STOP_FLAG = 0;
  localparam int FS1_WAIT_FLAG = 1;
  localparam int FS1_STANDBY_SEL = 2;
  localparam int FS1_DEEP_WAIT = 3;
  localparam int ADC1_VREF_OFF = 6;
  localparam int STAT_WAIT = 0;
  localparam int STAT_STOP = 1;
  localparam int STAT_SETTLE = 2;
  localparam int STAT_VREF_READY = 3;
  // Reset values
  localparam logic [7:0] FUNC_SEL0_RST = 8'h00;
  localparam logic [7:0] FUNC_SEL1_RST = 8'h00;
  localparam logic ADC1_VREF_OFF_RST = 1'b0;
  // Divider chain and watchdog
  localparam int DIV_W = 13;
  localparam int WDG32_BIT = 5;
  localparam int WDG512_BIT = 9;
  localparam int WDT_W = 12;
  localparam logic [11:0] WDT_SETTLE_LOAD = 12'hFFF;
  // Timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int VREF_SETTLE_NS = 1000;
  localparam logic [6:0] VREF_SETTLE_CYC = 7'((VREF_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  // Power states
  typedef enum logic [1:0] {ST_RUN, ST_WAIT, ST_STOP, ST_SETTLE} wsp_state_type;
endpackage

/* File: core/wsp_clk_gate.sv */
`timescale 1ns/100ps
`default_nettype none
module wsp_clk_gate #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic reset_i,
  // Source levels for the next cycle and run requests
  input wire logic [W-1:0] src_i,
  input wire logic [W-1:0] run_i,
  // Gated clocks
  output logic [W-1:0] clk_o
);
  typedef struct packed {
    logic [W-1:0] src;
    logic [W-1:0] en;
    logic [W-1:0] out;
  } wsp_gate_state_type;

  wsp_gate_state_type s_q;
  wsp_gate_state_type s_d;

  if (W < 1) begin : g_chk
    $error("wsp_clk_gate needs W of at least 1");
  end

  // Enable changes only while the source is low, so no runt pulse
  always_comb begin
    s_d = s_q;
    s_d.src = src_i;
    s_d.en = (s_q.src & s_q.en) | (~s_q.src & run_i);
    s_d.out = src_i & s_d.en;
  end

  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign clk_o = s_q.out;

  // Assertions
  a_no_runt_rise: assert property (@(posedge core_clk_i) disable iff (reset_i)
    (|(s_q.out & ~$past(s_q.out))) |-> ((s_q.out & ~$past(s_q.out) & $past(s_q.src)) == '0))
    else $error("gated clock rose while source was already high");
endmodule
`default_nettype wire

/* File: sim/wsp_bus_peer.sv */
`timescale 1ns/100ps
`default_nettype none
module wsp_bus_peer #(
  parameter int W = 44
) (
  // Clock
  input wire logic core_clk_i,
  // Pins as the board sees them
  input wire logic [W-1:0] pin_i,
  input wire logic [W-1:0] oe_i,
  // Resolved line levels
  output logic [W-1:0] line_o
);
  logic [W-1:0] last_q;
  // No pull resistors: a released line shows the inverse of its last level
  assign line_o = (pin_i & oe_i) | (~last_q & ~oe_i);
  // Remember each line level for the next cycle
  always_ff @(posedge core_clk_i) begin
    last_q <= line_o;
  end
endmodule
`default_nettype wire

/* File: sim/tb.sv */
`timescale 1ns/100ps
`default_nettype none
module tb;
  logic core_clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic [7:0] addr = 8'h00, wdata = 8'h00, rdata;
  logic wr = 1'b0, rd = 1'b0, byte_m = 1'b0;
  logic [2:0] evt = 3'h0;
  logic [23:0] paddr_dir = 24'hFFFFFF;
  logic [15:0] pdata_dir = 16'h0FF0;
  logic [23:0] b_addr = 24'h123456;
  logic [15:0] b_dout = 16'h1234;
  logic b_doe = 1'b1;
  logic [3:0] b_ctl = 4'h5;
  logic [3:0] pctl_dir = 4'hF;
  logic [23:0] a_pin, a_oe;
  logic [15:0] d_pin, d_oe;
  logic [3:0] c_pin, c_oe;
  logic [43:0] line;
  logic buc, coc, w32, w512, osc_run, osc_drv, osc_out;
  logic refr, adc, dma, wdt, evo, vref;
  logic [12:0] pdiv;
  logic [4:0] clks, moved;
  logic [7:0] d;
  int bad_count = 0;
  int checks_done = 0;
  int cyc = 0;
  int n;
  assign clks = {pdiv[0], w512, w32, coc, buc};
  // Clock and hang guard
  always #5 core_clk_i = ~core_clk_i;
  always @(posedge core_clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      bad_count = bad_count + 1;
      stop_test();
    end
  end
  wsp_top #(.SETTLE_LOAD(12'h800)) dut_u (
    .core_clk_i(core_clk_i), .reset_i(reset_i), .reg_addr_i(addr), .reg_wdata_i(wdata),
    .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata), .stop_instr_i(evt[0]),
    .wait_instr_i(evt[1]), .irq_accept_i(evt[2]), .byte_mode_i(byte_m),
    .bus_addr_i(b_addr), .bus_dout_i(b_dout), .bus_doe_i(b_doe), .bus_ctl_i(b_ctl),
    .port_addr_out_i(24'hA5C33C), .port_addr_dir_i(paddr_dir), .port_data_out_i(16'hBEEF),
    .port_data_dir_i(pdata_dir), .port_ctl_out_i(4'hA), .port_ctl_dir_i(pctl_dir),
    .addr_pin_o(a_pin), .addr_pin_oe_o(a_oe), .data_pin_o(d_pin), .data_pin_oe_o(d_oe),
    .ctl_pin_o(c_pin), .ctl_pin_oe_o(c_oe), .bus_unit_clock_o(buc), .core_clock_o(coc),
    .watchdog_div32_clock_o(w32), .watchdog_div512_clock_o(w512), .periph_div_clk_o(pdiv),
    .osc_run_o(osc_run), .osc_drive_en_o(osc_drv), .osc_output_pin_o(osc_out),
    .refresh_run_o(refr), .adc_run_o(adc), .dma_run_o(dma), .wdt_run_o(wdt),
    .event_only_o(evo), .vref_connect_o(vref)
  );
  // Board side of the external bus
  wsp_bus_peer #(.W(44)) peer_u (
    .core_clk_i(core_clk_i), .pin_i({a_pin, d_pin, c_pin}), .oe_i({a_oe, d_oe, c_oe}), .line_o(line)
  );
  // Compare and count
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks_done = checks_done + 1;
    if (seen !== exp) begin
      bad_count = bad_count + 1;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // Register write, one strobe cycle
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] v);
    @(posedge core_clk_i);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge core_clk_i);
    wr <= 1'b0;
  endtask
  // Register read, data in the cycle after the strobe
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] v);
    @(posedge core_clk_i);
    addr <= a;
    rd <= 1'b1;
    @(posedge core_clk_i);
    rd <= 1'b0;
    #1 v = rdata;
  endtask
  // One-cycle core event: 0 stop, 1 wait, 2 interrupt accepted
  task automatic pulse(input int k);
    @(posedge core_clk_i);
    evt[k] <= 1'b1;
    @(posedge core_clk_i);
    evt <= 3'h0;
    repeat (3) @(posedge core_clk_i);
    #1;
  endtask
  // Collect which clocks changed over n cycles
  task automatic watch(input int cnt);
    logic [4:0] prev;
    moved = 5'h00;
    prev = clks;
    repeat (cnt) begin
      @(posedge core_clk_i);
      #1 moved = moved | (clks ^ prev);
      prev = clks;
    end
  endtask
  // Closing report
  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge core_clk_i);
    reset_i <= 1'b0;
    rd_reg(8'h63, d);
    check("fs1_rst", d, 8'h00);
    @(posedge core_clk_i);
    #1 check("rdata_idle", rdata, 8'h00);
    rd_reg(8'h00, d);
    check("unmapped", d, 8'h00);
    // Bus owns the pins in run
    check("addr_run", line[43:20], 24'h123456);
    check("ctl_run", {c_oe, c_pin}, 8'hF5);
    // Plain wait
    wr_reg(8'h63, 8'h04);
    pulse(1);
    check("lv_wait", {refr, adc, dma, wdt, evo}, 5'b11000);
    check("addr_ho", a_pin, 24'hA5C33C);
    check("addr_oe", a_oe, 24'hFFFFFF);
    check("data_oe", d_oe, 16'h0FF0);
    check("data_ho", line[19:4] & 16'h0FF0, 16'h0EE0);
    check("ctl_ho", line[3:0], 4'hA);
    repeat (70) @(posedge core_clk_i);
    watch(70);
    check("clk_wait", {moved, clks[3:0]}, 9'h100);
    check("osc_wait", osc_run, 1'b1);
    rd_reg(8'h63, d);
    check("wflag", d, 8'h06);
    rd_reg(8'h68, d);
    check("st_wait", d[1:0], 2'b01);
    pulse(2);
    check("addr_back", a_pin, 24'h123456);
    check("dma_back", {dma, wdt}, 2'b11);
    watch(70);
    check("clk_run", moved & 5'b10111, 5'b10111);
    // Deep wait, bit set just before and cleared just after
    wr_reg(8'h63, 8'h08);
    pulse(1);
    check("lv_deep", {refr, adc, dma, wdt, evo, osc_run}, 6'b100011);
    repeat (70) @(posedge core_clk_i);
    watch(70);
    check("clk_deep", {moved, clks[3:0], pdiv[5:0]}, 15'h0000);
    check("addr_noho", a_pin, 24'h123456);
    pulse(2);
    wr_reg(8'h63, 8'h00);
    check("adc_back", {adc, evo}, 2'b10);
    // Byte bus mode keeps upper data and high write strobe as ports
    byte_m <= 1'b1;
    b_doe <= 1'b0;
    repeat (3) @(posedge core_clk_i);
    #1 check("byte_data", {d_oe, d_pin}, 32'h0F00BE34);
    check("byte_ctl", c_pin & 4'h4, 4'h0);
    @(posedge core_clk_i);
    byte_m <= 1'b0;
    b_doe <= 1'b1;
    // Stop refused while disabled
    wr_reg(8'h62, 8'h01);
    pulse(0);
    rd_reg(8'h68, d);
    check("stp_dis", d[1:0], 2'b00);
    // External clock: driver off, stop exit without settling
    wr_reg(8'h62, 8'h02);
    @(posedge core_clk_i);
    #1 check("ext_osc", {osc_drv, osc_out}, 2'b01);
    pulse(0);
    rd_reg(8'h68, d);
    check("st_stop", d[2:0], 3'b010);
    pulse(2);
    rd_reg(8'h68, d);
    check("ext_exit", d[2:0], 3'b000);
    watch(8);
    check("ext_clk", moved[0], 1'b1);
    wr_reg(8'h62, 8'h00);
    // Crystal stop exit waits on the watchdog top bit
    pulse(0);
    n = 0;
    while (osc_run !== 1'b0 && n < 9000) begin
      @(posedge core_clk_i);
      #1 n = n + 1;
    end
    check("osc_stop", osc_run, 1'b0);
    pulse(2);
    rd_reg(8'h68, d);
    check("settle", {d[2], buc, coc}, 3'b100);
    n = 0;
    while (coc !== 1'b1 && n < 400) begin
      @(posedge core_clk_i);
      #1 n = n + 1;
    end
    // One watchdog tick needs 32 cycles from a cleared divider; pulse and read used 5 of them
    check("settle_gt", n > 26, 1'b1);
    check("settle_end", coc, 1'b1);
    wr_reg(8'h63, 8'h00);
    // Reference ladder disconnect and reconnect
    wr_reg(8'h1F, 8'h40);
    @(posedge core_clk_i);
    #1 check("vref_off", vref, 1'b0);
    wr_reg(8'h1F, 8'h00);
    rd_reg(8'h68, d);
    check("vref_nrdy", {vref, d[3]}, 2'b10);
    repeat (100) @(posedge core_clk_i);
    rd_reg(8'h68, d);
    check("vref_rdy", d[3], 1'b1);
    stop_test();
  end
endmodule
`default_nettype wire
